/* File: pkg/stepper_move_pkg.sv */
/*
  Shared constants and types of the stepper move sequencer: register
  offsets, control bit positions, reset values, timing counts, state codes.
  Assumes a 200 MHz core clock and a 32-bit Avalon-MM register bus.
*/
package stepper_move_pkg;

  // clock and rate tick timing
  localparam int unsigned CLK_MHZ      = 200;
  localparam int unsigned RATE_TICK_NS = 10000;
  localparam int unsigned RATE_DIV_CYC = RATE_TICK_NS * CLK_MHZ / 1000;

  // register byte offsets
  localparam logic [5:0] OFS_CTRL  = 6'h00;
  localparam logic [5:0] OFS_SPEED = 6'h04;
  localparam logic [5:0] OFS_RAMP  = 6'h08;
  localparam logic [5:0] OFS_TGT   = 6'h0c;
  localparam logic [5:0] OFS_MIND  = 6'h10;
  localparam logic [5:0] OFS_TRAIL = 6'h14;
  localparam logic [5:0] OFS_DWELL = 6'h18;
  localparam logic [5:0] OFS_SEG   = 6'h1c;
  localparam logic [5:0] OFS_STAT  = 6'h20;
  localparam logic [5:0] OFS_POS   = 6'h24;
  localparam logic [5:0] OFS_ENC   = 6'h28;

  // control register bit positions
  localparam int unsigned C_REG_POS  = 0;
  localparam int unsigned C_REG_NEG  = 1;
  localparam int unsigned C_ENC_GO   = 2;
  localparam int unsigned C_ENC_ABS  = 3;
  localparam int unsigned C_ASM_GO   = 4;
  localparam int unsigned C_ASM_DWL  = 5;
  localparam int unsigned C_DIR_CW   = 6;
  localparam int unsigned C_DIR_CCW  = 7;
  localparam int unsigned C_HOLD     = 8;
  localparam int unsigned C_RESUME   = 9;
  localparam int unsigned C_IMM_STOP = 10;
  localparam int unsigned C_RST_ERR  = 11;
  localparam int unsigned C_PROG     = 12;
  localparam int unsigned C_SEG_VAL  = 13;
  localparam int unsigned C_ENC_MODE = 14;

  // reset values
  localparam logic [15:0] CTRL_RST  = 16'h0000;
  localparam logic [31:0] SPEED_RST = 32'h0100_0010;
  localparam logic [15:0] RAMP_RST  = 16'h0101;
  localparam logic [23:0] ZERO24    = 24'h000000;

  typedef enum logic [4:0] {
    ST_IDLE  = 5'b00001,
    ST_RUN   = 5'b00010,
    ST_STOP  = 5'b00100,
    ST_DWELL = 5'b01000,
    ST_HELD  = 5'b10000
  } state_t;

  typedef enum logic [1:0] {
    K_REG   = 2'h0,
    K_ENC   = 2'h1,
    K_BLEND = 2'h2,
    K_DWELL = 2'h3
  } kind_t;

  typedef struct packed {
    state_t      st;
    kind_t       kind;
    logic        dir;      // 1 = clockwise
    logic [15:0] spd;
    logic [15:0] tspd;
    logic [7:0]  acc;
    logic [7:0]  dec;
    logic [23:0] phase;
    logic [23:0] left;
    logic [23:0] ramp;
    logic [23:0] minl;
    logic        end_cnt;  // stop ends when left reaches zero
    logic        to_hold;  // stop ends in the held state
    logic        pend;     // registration stop pending
    logic [3:0]  seg;
    logic [15:0] dwl;
    logic [23:0] enc_t;
    logic [23:0] pos;
    logic        lock_cw;
    logic        lock_ccw;
    logic        err;
  } mv_t;

endpackage : stepper_move_pkg

/* File: logic/stepper_move_sequencer.sv */
/*
  Move-profile sequencer for a stepper indexer: registration, encoder,
  blend and dwell moves, segment loading handshake, Avalon-MM registers.
  Assumes pins are asynchronous to core_clk_i and a single 200 MHz clock.
*/
// What this block does
// - registration move steps in commanded direction while its command bit stays set.
// - controlled stop of registration move emits programmed trailing steps, relative.
// - trailing count shorter than ramp: decelerate, then halt abruptly at the count.
// - opposite limit switch is ignored during a registration move.
// - stops ignored until minimum distance stepped; stop condition is level sampled.
// - registration stops on command bit low or stop input rising edge.
// - hold on registration decelerates without trailing steps, no held state.
// - immediate stop on command bit rising or emergency input rising.
// - limit in travel direction stops at once and locks that way until error reset.
// - start allowed with active limit when moving away from it.
// - start with stop input active gives minimum distance plus trailing steps.
// - encoder mode runs moves from encoder position, absolute or relative.
// - relative encoder move needs no preset or homing.
// - encoder move starts decelerating when programmed encoder position is reached.
// - hold on encoder move decelerates into held state; resume or new move follows.
// - new single move refused until the running one completes or stops.
// - assembled move has two to sixteen loaded relative segments, one start command.
// - blend move runs segments back to back in one direction without halting.
// - dwell move halts for dwell time between segments; direction may reverse.
// - blend uses segment magnitudes only; direction from the two start bits.
// - blend speeds at least start speed, distinct; new accel up, old decel down.
// - stored segments kept until reprogrammed, so a move can rerun many times.
// - segment handshake: request, host valid, request clears, valid drops, next request.
`timescale 1ns/1ps
module stepper_move_sequencer
  import stepper_move_pkg::*;
#(
  parameter int unsigned RATE_DIV = RATE_DIV_CYC,
  parameter int unsigned SEG_MAX  = 16,
  parameter int unsigned SEG_MIN  = 2
)
(
  input  wire logic        core_clk_i,
  input  wire logic        reset_i,
  input  wire logic [5:0]  avs_address_i,
  input  wire logic        avs_read_i,
  input  wire logic        avs_write_i,
  input  wire logic [31:0] avs_writedata_i,
  input  wire logic [3:0]  avs_byteenable_i,
  output logic      [31:0] avs_readdata_o,
  output logic             avs_waitrequest_o,
  input  wire logic        stop_in_i,
  input  wire logic        estop_i,
  input  wire logic        cw_limit_i,
  input  wire logic        ccw_limit_i,
  input  wire logic        enc_a_i,
  input  wire logic        enc_b_i,
  output logic             step_o,
  output logic             dir_o,
  output logic             busy_o
);

  // elaboration checks on parameters
  if (SEG_MAX > 16 || SEG_MIN < 2 || SEG_MIN > SEG_MAX || RATE_DIV < 1)
  begin : g_bad_param
    $error("stepper_move_sequencer: unsupported parameter values");
  end

  logic [15:0] ctrl, next_ctrl, ctrl_d;
  logic [31:0] speed_r, next_speed_r;
  logic [15:0] ramp_r, next_ramp_r, dwell_r, next_dwell_r;
  logic [23:0] tgt_r, next_tgt_r, mind_r, next_mind_r, trail_r, next_trail_r;
  logic [31:0] seg_r, next_seg_r, next_readdata;
  logic        next_waitrequest, wr_ok;
  logic [5:0]  in_s1, in_s2, in_s3;
  logic [23:0] enc_pos, next_enc_pos;
  logic [15:0] rate_cnt, next_rate_cnt;
  logic        tick;
  mv_t         mv, n;
  logic        step_ev;
  logic [24:0] phase_sum;
  logic        prog_mode, next_prog_mode, seg_req, next_seg_req, seg_bad, next_seg_bad;
  logic [4:0]  seg_cnt, next_seg_cnt;
  logic        seg_we, seg_err_ev;
  logic signed [15:0] seg_tgt [SEG_MAX];
  logic [15:0] seg_spd [SEG_MAX];
  logic [15:0] seg_ramp [SEG_MAX];

  // byte-lane merge for partial writes
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                        input logic [3:0] be);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++)
    begin
      if (be[i]) r[8*i +: 8] = nw[8*i +: 8];
    end
    return r;
  endfunction : merge

  // bus slave: one wait cycle, then the access completes
  always_comb
  begin
    next_waitrequest = !((avs_read_i || avs_write_i) && avs_waitrequest_o);
    wr_ok        = avs_write_i && !avs_waitrequest_o;
    next_ctrl    = ctrl;
    next_speed_r = speed_r;
    next_ramp_r  = ramp_r;
    next_tgt_r   = tgt_r;
    next_mind_r  = mind_r;
    next_trail_r = trail_r;
    next_dwell_r = dwell_r;
    next_seg_r   = seg_r;
    if (wr_ok)
    begin
      unique case (avs_address_i)
        OFS_CTRL:  next_ctrl    = 16'(merge({16'h0, ctrl}, avs_writedata_i, avs_byteenable_i));
        OFS_SPEED: next_speed_r = merge(speed_r, avs_writedata_i, avs_byteenable_i);
        OFS_RAMP:  next_ramp_r  = 16'(merge({16'h0, ramp_r}, avs_writedata_i, avs_byteenable_i));
        OFS_TGT:   next_tgt_r   = 24'(merge({8'h0, tgt_r}, avs_writedata_i, avs_byteenable_i));
        OFS_MIND:  next_mind_r  = 24'(merge({8'h0, mind_r}, avs_writedata_i, avs_byteenable_i));
        OFS_TRAIL: next_trail_r = 24'(merge({8'h0, trail_r}, avs_writedata_i, avs_byteenable_i));
        OFS_DWELL: next_dwell_r = 16'(merge({16'h0, dwell_r}, avs_writedata_i, avs_byteenable_i));
        OFS_SEG:   next_seg_r   = merge(seg_r, avs_writedata_i, avs_byteenable_i);
        default:   next_seg_r   = seg_r;  // unmapped writes are dropped
      endcase
    end
    next_readdata = 32'h0000_0000;  // unmapped reads return zero
    if (avs_read_i && avs_waitrequest_o)
    begin
      unique case (avs_address_i)
        OFS_CTRL:  next_readdata = {16'h0000, ctrl};
        OFS_SPEED: next_readdata = speed_r;
        OFS_RAMP:  next_readdata = {16'h0000, ramp_r};
        OFS_TGT:   next_readdata = {8'h00, tgt_r};
        OFS_MIND:  next_readdata = {8'h00, mind_r};
        OFS_TRAIL: next_readdata = {8'h00, trail_r};
        OFS_DWELL: next_readdata = {16'h0000, dwell_r};
        OFS_SEG:   next_readdata = seg_r;
        OFS_STAT:  next_readdata = {9'h000, seg_cnt, mv.seg, seg_bad, seg_req, prog_mode,
                                    mv.lock_ccw, mv.lock_cw, mv.err, mv.dir, mv.kind, mv.st};
        OFS_POS:   next_readdata = {8'h00, mv.pos};
        OFS_ENC:   next_readdata = {8'h00, enc_pos};
        default:   next_readdata = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge core_clk_i)
  begin
    if (reset_i)
    begin
      avs_waitrequest_o <= 1'b1;
      avs_readdata_o    <= 32'h0000_0000;
      ctrl    <= CTRL_RST;
      speed_r <= SPEED_RST;
      ramp_r  <= RAMP_RST;
      tgt_r   <= ZERO24;
      mind_r  <= ZERO24;
      trail_r <= ZERO24;
      dwell_r <= 16'h0000;
      seg_r   <= 32'h0000_0000;
    end
    else
    begin
      avs_waitrequest_o <= next_waitrequest;
      avs_readdata_o    <= next_readdata;
      ctrl    <= next_ctrl;
      speed_r <= next_speed_r;
      ramp_r  <= next_ramp_r;
      tgt_r   <= next_tgt_r;
      mind_r  <= next_mind_r;
      trail_r <= next_trail_r;
      dwell_r <= next_dwell_r;
      seg_r   <= next_seg_r;
    end
  end

  // pins: bit 0 stop, 1 estop, 2 cw limit, 3 ccw limit, 4 enc a, 5 enc b
  wire logic stop_rise = in_s2[0] && !in_s3[0];
  wire logic estop_rise = in_s2[1] && !in_s3[1];
  wire logic [15:0] rise = ctrl & ~ctrl_d;

  // quadrature decode; both phases changing at once is dropped as noise
  always_comb
  begin
    next_enc_pos = enc_pos;
    if ((in_s2[4] ^ in_s3[4]) != (in_s2[5] ^ in_s3[5]))
    begin
      if (in_s2[4] ^ in_s3[5]) next_enc_pos = enc_pos + 24'h000001;
      else next_enc_pos = enc_pos - 24'h000001;
    end
    next_rate_cnt = (rate_cnt == 16'(RATE_DIV - 1)) ? 16'h0000 : rate_cnt + 16'h0001;
  end

  assign tick = (rate_cnt == 16'h0000);

  always_ff @(posedge core_clk_i)
  begin
    if (reset_i)
    begin
      in_s1    <= 6'h00;
      in_s2    <= 6'h00;
      in_s3    <= 6'h00;
      ctrl_d   <= CTRL_RST;
      enc_pos  <= ZERO24;
      rate_cnt <= 16'h0000;
    end
    else
    begin
      in_s1    <= {enc_b_i, enc_a_i, ccw_limit_i, cw_limit_i, estop_i, stop_in_i};
      in_s2    <= in_s1;
      in_s3    <= in_s2;
      ctrl_d   <= ctrl;
      enc_pos  <= next_enc_pos;
      rate_cnt <= next_rate_cnt;
    end
  end

  // segment loading handshake and speed checks
  wire logic [15:0] sp_new = seg_r[31:16];
  wire logic [3:0]  wr_idx = seg_cnt[3:0];
  wire logic [3:0]  prv_idx = wr_idx - 4'h1;
  always_comb
  begin
    next_prog_mode = prog_mode;
    next_seg_req   = seg_req;
    next_seg_cnt   = seg_cnt;
    next_seg_bad   = seg_bad;
    seg_we         = 1'b0;
    seg_err_ev     = 1'b0;
    if (rise[C_PROG])
    begin
      next_prog_mode = 1'b1;
      next_seg_req   = 1'b1;
      next_seg_cnt   = 5'h00;
      next_seg_bad   = 1'b0;
    end
    else if (prog_mode && !ctrl[C_PROG])
    begin
      next_prog_mode = 1'b0;
      next_seg_req   = 1'b0;
    end
    else if (prog_mode && seg_req && ctrl[C_SEG_VAL])
    begin
      next_seg_req = 1'b0;
      if (seg_cnt < 5'(SEG_MAX))
      begin
        seg_we       = 1'b1;
        next_seg_cnt = seg_cnt + 5'h01;
        if (sp_new < speed_r[15:0] || (seg_cnt != 5'h00 && sp_new == seg_spd[prv_idx]))
        begin
          next_seg_bad = 1'b1;
          seg_err_ev   = 1'b1;
        end
      end
      else seg_err_ev = 1'b1;  // too many segments
    end
    else if (prog_mode && !seg_req && !ctrl[C_SEG_VAL] && seg_cnt < 5'(SEG_MAX))
      next_seg_req = 1'b1;
  end

  always_ff @(posedge core_clk_i)
  begin
    if (reset_i)
    begin
      prog_mode <= 1'b0;
      seg_req   <= 1'b0;
      seg_cnt   <= 5'h00;
      seg_bad   <= 1'b0;
    end
    else
    begin
      prog_mode <= next_prog_mode;
      seg_req   <= next_seg_req;
      seg_cnt   <= next_seg_cnt;
      seg_bad   <= next_seg_bad;
    end
    if (seg_we)
    begin
      seg_tgt[wr_idx]  <= $signed(seg_r[15:0]);
      seg_spd[wr_idx]  <= sp_new;
      seg_ramp[wr_idx] <= ramp_r;
    end
  end

  // motion helpers
  wire logic [15:0] st_spd = speed_r[15:0];
  wire logic cw_l = in_s2[2];
  wire logic ccw_l = in_s2[3];
  wire logic moving = (mv.st == ST_RUN) || (mv.st == ST_STOP);
  wire logic lim_fwd = mv.dir ? cw_l : ccw_l;
  wire logic [16:0] dn_thr = {1'b0, st_spd} + {9'h000, mv.dec};
  wire logic [15:0] spd_dn = ({1'b0, mv.spd} > dn_thr) ? mv.spd - {8'h00, mv.dec} : st_spd;
  wire logic last_seg = ({1'b0, mv.seg} == seg_cnt - 5'h01);
  wire logic [3:0] nx = mv.seg + 4'h1;
  wire logic signed [15:0] nx_t = seg_tgt[nx];
  wire logic signed [15:0] s0_t = seg_tgt[0];
  wire logic [15:0] nx_mag = nx_t[15] ? 16'(-nx_t) : nx_t;
  wire logic [15:0] s0_mag = s0_t[15] ? 16'(-s0_t) : s0_t;
  wire logic enc_hit = mv.dir ? ($signed(enc_pos) >= $signed(mv.enc_t))
                              : ($signed(enc_pos) <= $signed(mv.enc_t));
  wire logic busy_mv = (mv.st != ST_IDLE) && (mv.st != ST_HELD);
  wire logic go_reg = rise[C_REG_POS] || rise[C_REG_NEG];
  wire logic go_any = go_reg || rise[C_ENC_GO] || rise[C_ASM_GO];
  wire logic asm_dir_ok = ctrl[C_DIR_CW] ^ ctrl[C_DIR_CCW];
  wire logic [23:0] enc_dest = ctrl[C_ENC_ABS] ? tgt_r : enc_pos + tgt_r;
  logic go_dir;

  // start direction of the requested move
  always_comb
  begin
    if (go_reg) go_dir = rise[C_REG_POS];
    else if (rise[C_ENC_GO]) go_dir = !($signed(enc_dest) < $signed(enc_pos));
    else if (ctrl[C_ASM_DWL]) go_dir = !s0_t[15];
    else go_dir = ctrl[C_DIR_CW];
  end

  wire logic go_block = go_dir ? (cw_l || mv.lock_cw) : (ccw_l || mv.lock_ccw);

  // main motion sequencer
  always_comb
  begin
    n         = mv;
    phase_sum = {1'b0, mv.phase} + {9'h000, mv.spd};
    step_ev   = moving && phase_sum[24];
    if (moving) n.phase = phase_sum[23:0];
    if (step_ev)
    begin
      n.pos = mv.dir ? mv.pos + 24'h000001 : mv.pos - 24'h000001;
      if (mv.left != ZERO24) n.left = mv.left - 24'h000001;
      if (mv.minl != ZERO24) n.minl = mv.minl - 24'h000001;
      if (mv.st == ST_RUN && mv.spd < mv.tspd) n.ramp = mv.ramp + 24'h000001;
    end
    // speed ramp once per rate tick; only the stop ramp is floored at start speed
    if (tick && mv.st == ST_RUN)
    begin
      if (mv.spd < mv.tspd)
        n.spd = (17'(mv.spd) + 17'(mv.acc) < 17'(mv.tspd)) ? mv.spd + 16'(mv.acc) : mv.tspd;
      else if (mv.spd > mv.tspd)
        n.spd = (mv.spd > mv.tspd + 16'(mv.dec)) ? mv.spd - 16'(mv.dec) : mv.tspd;
      else if (mv.kind == K_BLEND) n.dec = seg_ramp[mv.seg][15:8];
    end
    if (tick && mv.st == ST_STOP) n.spd = spd_dn;
    if (mv.st == ST_RUN && mv.kind == K_REG && stop_rise) n.pend = 1'b1;
    if (mv.st == ST_DWELL && tick && mv.dwl != 16'h0000) n.dwl = mv.dwl - 16'h0001;

    unique case (mv.st)
      ST_RUN:
      begin
        if (rise[C_HOLD])
        begin
          n.st = ST_STOP;
          n.end_cnt = 1'b0;
          n.to_hold = (mv.kind == K_ENC);
        end
        else if (mv.kind == K_REG)
        begin
          // level sampled after the minimum distance
          if (mv.minl == ZERO24 && (mv.pend || !ctrl[mv.dir ? C_REG_POS : C_REG_NEG]))
          begin
            n.st = ST_STOP;
            n.end_cnt = 1'b1;
            n.left = trail_r;
          end
        end
        else if (mv.kind == K_ENC)
        begin
          if (enc_hit) n.st = ST_STOP;
        end
        else if (mv.left == ZERO24 && mv.kind == K_BLEND && !last_seg)
        begin
          // next blend segment without stopping the shaft
          n.seg  = nx;
          n.left = {8'h00, nx_mag};
          n.tspd = seg_spd[nx];
          if (seg_spd[nx] > mv.tspd) n.acc = seg_ramp[nx][7:0];
        end
        else if (mv.left <= mv.ramp && (mv.kind == K_DWELL || last_seg))
        begin
          n.st = ST_STOP;
          n.end_cnt = 1'b1;
        end
      end
      ST_STOP:
      begin
        if (mv.end_cnt ? (mv.left == ZERO24) : (mv.spd == st_spd))
        begin
          // trailing count may end before the ramp does: halt there
          n.st = ST_IDLE;
          if (mv.to_hold) n.st = ST_HELD;
          else if (mv.end_cnt && mv.kind == K_DWELL && !last_seg)
          begin
            n.st  = ST_DWELL;
            n.dwl = dwell_r;
          end
        end
      end
      ST_DWELL:
      begin
        if (mv.dwl == 16'h0000)
        begin
          n.st   = ST_RUN;
          n.seg  = nx;
          n.dir  = !nx_t[15];
          n.left = {8'h00, nx_mag};
          n.tspd = seg_spd[nx];
          n.spd  = st_spd;
          n.acc  = seg_ramp[nx][7:0];
          n.dec  = seg_ramp[nx][15:8];
          n.ramp = ZERO24;
        end
      end
      ST_HELD:
      begin
        if (rise[C_RESUME])
        begin
          n.st = ST_RUN;
          n.tspd = speed_r[31:16];
          n.acc = ramp_r[7:0];
          n.dec = ramp_r[15:8];
          n.to_hold = 1'b0;
        end
      end
      ST_IDLE: n.st = ST_IDLE;
    endcase

    // error reset clears first, so a new error in the same cycle wins
    if (rise[C_RST_ERR])
    begin
      n.err = 1'b0;
      n.lock_cw = 1'b0;
      n.lock_ccw = 1'b0;
    end
    // move start; a held encoder move may be abandoned
    if (go_any)
    begin
      if (busy_mv || go_block) n.err = 1'b1;
      else if (rise[C_ENC_GO] && !ctrl[C_ENC_MODE]) n.err = 1'b1;
      else if (rise[C_ASM_GO] && (seg_cnt < 5'(SEG_MIN) || prog_mode
               || (!ctrl[C_ASM_DWL] && (seg_bad || !asm_dir_ok)))) n.err = 1'b1;
      else
      begin
        n.st = ST_RUN;
        n.dir = go_dir;
        n.spd = st_spd;
        n.tspd = speed_r[31:16];
        n.acc = ramp_r[7:0];
        n.dec = ramp_r[15:8];
        n.phase = ZERO24;
        n.ramp = ZERO24;
        n.left = ZERO24;
        n.minl = mind_r;
        n.end_cnt = 1'b0;
        n.to_hold = 1'b0;
        n.pend = in_s2[0];
        n.seg = 4'h0;
        n.kind = K_REG;
        if (rise[C_ENC_GO])
        begin
          n.kind = K_ENC;
          n.enc_t = enc_dest;
        end
        else if (rise[C_ASM_GO])
        begin
          n.kind = ctrl[C_ASM_DWL] ? K_DWELL : K_BLEND;
          n.left = {8'h00, s0_mag};
          n.tspd = seg_spd[0];
          n.acc = seg_ramp[0][7:0];
          n.dec = seg_ramp[0][15:8];
        end
      end
    end

    // immediate stops override everything; only the forward limit counts
    if (moving && lim_fwd)
    begin
      n.st = ST_IDLE;
      if (mv.dir) n.lock_cw = 1'b1;
      else n.lock_ccw = 1'b1;
    end
    if (rise[C_IMM_STOP] || estop_rise) n.st = ST_IDLE;
    if (seg_err_ev) n.err = 1'b1;
    if (moving && lim_fwd) n.lock_cw = mv.dir || n.lock_cw;
    if (moving && lim_fwd) n.lock_ccw = !mv.dir || n.lock_ccw;
  end

  always_ff @(posedge core_clk_i)
  begin
    if (reset_i)
    begin
      mv     <= '{st: ST_IDLE, kind: K_REG, default: '0};
      step_o <= 1'b0;
      busy_o <= 1'b0;
    end
    else
    begin
      mv     <= n;
      step_o <= step_ev;
      busy_o <= (n.st != ST_IDLE);
    end
  end

  assign dir_o = mv.dir;

endmodule : stepper_move_sequencer

/* File: dv/stepper_move_chk.sv */
/*
  port checker of the move sequencer: bus handshake, step pulses, stops.
  assumes a bind onto the top module and one clock with sync reset.
*/
`timescale 1ns/1ps
module stepper_move_chk (
  input wire logic        core_clk_i,
  input wire logic        reset_i,
  input wire logic [5:0]  avs_address_i,
  input wire logic        avs_read_i,
  input wire logic        avs_write_i,
  input wire logic [31:0] avs_readdata_o,
  input wire logic        avs_waitrequest_o,
  input wire logic        estop_i,
  input wire logic        cw_limit_i,
  input wire logic        step_o,
  input wire logic        dir_o,
  input wire logic        busy_o
);
  // one clock domain, reset masks everything
  default clocking @(posedge core_clk_i); endclocking
  default disable iff (reset_i);
  property p_wait_once; !avs_waitrequest_o |=> avs_waitrequest_o; endproperty
  a_wait_once: assert property (p_wait_once) else $error("wait low twice");
  property p_answer; (avs_read_i || avs_write_i) && avs_waitrequest_o |=> !avs_waitrequest_o;
  endproperty
  a_answer: assert property (p_answer) else $error("no bus answer");
  property p_unmapped;
    avs_read_i && !avs_waitrequest_o && avs_address_i > 6'h28 |-> avs_readdata_o == 32'h0;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
  property p_step_pulse; step_o |=> !step_o; endproperty
  a_step_pulse: assert property (p_step_pulse) else $error("step too long");
  property p_step_busy; step_o |-> busy_o || $past(busy_o); endproperty
  a_step_busy: assert property (p_step_busy) else $error("step while idle");
  property p_estop; $rose(estop_i) |-> ##[1:6] !busy_o; endproperty
  a_estop: assert property (p_estop) else $error("estop ignored");
  property p_cw_lim; $rose(cw_limit_i) && dir_o && busy_o |-> ##[1:6] !busy_o; endproperty
  a_cw_lim: assert property (p_cw_lim) else $error("limit ignored");
  property p_stop_quiet; $fell(busy_o) |=> !step_o [*4]; endproperty
  a_stop_quiet: assert property (p_stop_quiet) else $error("step after stop");
  // main scenarios reached
  c_step: cover property (step_o);
  c_estop: cover property ($rose(estop_i) && busy_o);
  c_unmapped: cover property (avs_read_i && !avs_waitrequest_o && avs_address_i > 6'h28);
endmodule : stepper_move_chk

/* File: dv/stepper_motor_model.sv */
/*
  motor with quadrature encoder: counts step pulses, turns them into phases.
  assumes one step pulse is one encoder count; lines never float.
*/
`timescale 1ns/1ps
module stepper_motor_model (
  input  wire logic core_clk_i,
  input  wire logic step_i,
  input  wire logic dir_i,
  output logic      enc_a_o,
  output logic      enc_b_o,
  output int        steps_o
);
  logic [1:0] ph;
  initial
  begin
    ph = 2'h0;
    steps_o = 0;
  end
  // gray phase walks forward when clockwise, backward otherwise
  always @(posedge core_clk_i)
  begin
    if (step_i)
    begin
      ph <= dir_i ? ph + 2'h1 : ph - 2'h1;
      steps_o <= steps_o + 1;
    end
  end
  assign enc_a_o = ph[1] ^ ph[0];
  assign enc_b_o = ph[1];
endmodule : stepper_motor_model

/* File: dv/stepper_move_sequencer_tb.sv */
/*
  testbench of the move sequencer: Avalon tasks, registration, stops, segments.
  assumes the motor model on the step pins and a short rate divider.
*/
`timescale 1ns/1ps
module stepper_move_sequencer_tb;
  import stepper_move_pkg::*;
  logic        core_clk_i, reset_i, avs_read_i, avs_write_i, stop_in_i, estop_i;
  logic        cw_limit_i, ccw_limit_i, enc_a_i, enc_b_i, step_o, dir_o, busy_o;
  logic        avs_waitrequest_o;
  logic [5:0]  avs_address_i;
  logic [31:0] avs_writedata_i, avs_readdata_o, st;
  int          miscompares, checked, steps, base;
  stepper_move_sequencer #(.RATE_DIV(4)) uut (.avs_byteenable_i(4'hf), .*);
  stepper_motor_model motor (.core_clk_i, .step_i(step_o), .dir_i(dir_o),
    .enc_a_o(enc_a_i), .enc_b_o(enc_b_i), .steps_o(steps));
  task automatic close_out;
    $display("checked %0d miscompares %0d", checked, miscompares);
    if (miscompares == 0 && checked > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : close_out
  task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] e);
    checked++;
    if (s !== e)
    begin
      miscompares++;
      $display("[ERR] %s exp %h seen %h", nm, e, s);
    end
  endtask : chk
  // one access, held until waitrequest is seen low
  task automatic bus(input logic w, input logic [5:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge core_clk_i);
    avs_address_i <= a;
    avs_writedata_i <= d;
    avs_write_i <= w;
    avs_read_i <= !w;
    @(posedge core_clk_i);
    while (avs_waitrequest_o !== 1'b0 && n < 50)
    begin
      @(posedge core_clk_i);
      n++;
    end
    st = avs_readdata_o;
    avs_write_i <= 1'b0;
    avs_read_i <= 1'b0;
    if (n == 50) chk("bus answer", 1, 0);
  endtask : bus
  // status twice: commands land a cycle after the write
  task automatic rs;
    bus(1'b0, OFS_STAT, 32'h0);
    bus(1'b0, OFS_STAT, 32'h0);
  endtask : rs
  task automatic wt(input logic v);
    int n;
    n = 0;
    while (busy_o !== v && n < 20000)
    begin
      @(posedge core_clk_i);
      n++;
    end
    if (n == 20000)
    begin
      chk("busy", busy_o, v);
      close_out;
    end
  endtask : wt
  // 200 MHz clock
  initial
  begin
    core_clk_i = 1'b0;
    forever #2.5 core_clk_i = ~core_clk_i;
  end
  // main sequence
  initial
  begin
    {reset_i, avs_read_i, avs_write_i, stop_in_i, estop_i, cw_limit_i, ccw_limit_i} = 7'h40;
    avs_address_i = 6'h00;
    avs_writedata_i = 32'h0;
    miscompares = 0;
    checked = 0;
    repeat (8) @(posedge core_clk_i);
    reset_i <= 1'b0;
    bus(1'b0, OFS_SPEED, 0); chk("speed", st, SPEED_RST);
    bus(1'b0, OFS_RAMP, 0); chk("ramp", st, {16'h0, RAMP_RST});
    bus(1'b0, 6'h3c, 0); chk("unmapped", st, 0);
    $display("reset values done");
    bus(1'b1, OFS_SPEED, 32'hffff_ffff);
    bus(1'b1, OFS_MIND, 5);
    bus(1'b1, OFS_TRAIL, 3);
    stop_in_i <= 1'b1;
    base = steps;
    bus(1'b1, OFS_CTRL, 1); wt(1); wt(0);
    chk("min plus trail", steps - base, 8);
    stop_in_i <= 1'b0;
    bus(1'b1, OFS_CTRL, 0);
    for (int d = 0; d < 2; d++)
    begin
      ccw_limit_i <= (d == 0);
      base = steps;
      bus(1'b1, OFS_CTRL, d ? 2 : 1); wt(1); chk("dir", dir_o, !d);
      for (int k = 0; k < 4000 && steps - base < 6; k++) @(posedge core_clk_i);
      if (d) stop_in_i <= 1'b1; else bus(1'b1, OFS_CTRL, 0);
      base = steps;
      wt(0); chk("trail", steps - base, 3);
      {stop_in_i, ccw_limit_i} <= 2'h0;
      bus(1'b1, OFS_CTRL, 0);
    end
    $display("registration done");
    for (int d = 0; d < 2; d++)
    begin
      bus(1'b1, OFS_CTRL, d ? 1 : 2); wt(1);
      if (d) cw_limit_i <= 1'b1; else ccw_limit_i <= 1'b1;
      wt(0);
      {cw_limit_i, ccw_limit_i} <= 2'h0;
      bus(1'b1, OFS_CTRL, 0); bus(1'b1, OFS_CTRL, d ? 1 : 2); rs;
      chk("lock", st[10-d], 1); chk("refused", busy_o, 0);
      bus(1'b1, OFS_CTRL, 0); bus(1'b1, OFS_CTRL, 32'h800); bus(1'b1, OFS_CTRL, 0);
    end
    rs; chk("errors clear", st[10:8], 0);
    bus(1'b1, OFS_CTRL, 1); wt(1); bus(1'b1, OFS_CTRL, 32'h400);
    base = steps; wt(0); chk("imm stop", steps - base, 0);
    bus(1'b1, OFS_CTRL, 0); bus(1'b1, OFS_CTRL, 1); wt(1); estop_i <= 1'b1;
    base = steps; wt(0); chk("estop", steps - base, 0);
    estop_i <= 1'b0;
    bus(1'b1, OFS_CTRL, 0);
    bus(1'b1, OFS_TGT, 4); bus(1'b1, OFS_CTRL, 32'h4004); wt(1); wt(0);
    bus(1'b0, OFS_ENC, 0); chk("enc moved", st[23:0] != 0, 1);
    bus(1'b1, OFS_CTRL, 0);
    $display("stops done");
    bus(1'b1, OFS_SPEED, 32'hffff_8000); bus(1'b1, OFS_CTRL, 32'h1000);
    for (int s = 0; s < 2; s++)
    begin
      rs; chk("seg req", st[12:11], 2'h3);
      bus(1'b1, OFS_SEG, s ? 32'h8000_0002 : 32'hffff_fffd);
      bus(1'b1, OFS_CTRL, 32'h3000); rs; chk("req clear", st[12], 0);
      bus(1'b1, OFS_CTRL, 32'h1000);
    end
    bus(1'b1, OFS_CTRL, 0); rs; chk("seg count", {st[22:18], st[12:11]}, 7'h08);
    for (int d = 0; d < 2; d++)
    begin
      base = steps;
      bus(1'b1, OFS_CTRL, d ? 32'h90 : 32'h50); wt(1); chk("dir", dir_o, !d);
      wt(0); chk("blend", steps - base, 5);
      bus(1'b1, OFS_CTRL, 0);
    end
    bus(1'b1, OFS_CTRL, 32'h1000); bus(1'b1, OFS_SEG, 32'h0010_0004);
    bus(1'b1, OFS_CTRL, 32'h3000); rs; chk("bad speed", st[13], 1);
    bus(1'b1, OFS_CTRL, 0);
    $display("assembled done");
    close_out;
  end
endmodule : stepper_move_sequencer_tb
bind stepper_move_sequencer stepper_move_chk chk (.*);
